// *** src/ccpp_pkg.sv ***
// Shared types and constants for the charge cycle and power path control
package ccpp_pkg;

    // Charge sequencer states
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_TRICKLE = 3'b001,
        ST_PRE     = 3'b010,
        ST_FAST    = 3'b011,
        ST_DONE    = 3'b100,
        ST_FAULT   = 3'b101
    } ccpp_state_type;

    // Current level requested from the analog charge loop
    typedef enum logic [1:0] {
        CUR_OFF     = 2'b00,
        CUR_TRICKLE = 2'b01,
        CUR_PRE     = 2'b10,
        CUR_FAST    = 2'b11
    } ccpp_cur_type;

    // Rail source select codes
    localparam logic [1:0] RAIL_NORMAL = 2'h0;
    localparam logic [1:0] RAIL_FORCE_CELL = 2'h1;
    localparam logic [1:0] RAIL_FLOAT = 2'h2;
    localparam logic [1:0] RAIL_PULLDOWN = 2'h3;

    // Input sag select code that switches the loop off
    localparam logic [1:0] SAG_OFF_CODE = 2'h3;

    // Regulation target clamp, millivolts; target field in 10 mV steps
    localparam int TARGET_STEP_MV = 10;
    localparam int TARGET_MAX_MV = 4650;
    localparam logic [9:0] TARGET_MAX_CODE = 10'(TARGET_MAX_MV / TARGET_STEP_MV);

    // Droop headroom above the cell, millivolts
    localparam logic [7:0] DROOP_MV = 8'h64;
    localparam logic [7:0] DROOP_LOW_MV = 8'h32;
    localparam logic [7:0] TRACK_MV = 8'hE1;

    // Precharge timer is a quarter of the fast timer
    localparam int PRE_SHIFT = 2;
    // Precharge current without termination: 20 percent, as 1/5
    localparam int PRE_DIV = 5;

    // Timebase: one tick each minute at 250 MHz
    localparam int CLK_MHZ = 250;
    localparam int TICK_SEC = 60;
    localparam longint TICK_CYCLES = longint'(CLK_MHZ) * 1000000 * TICK_SEC;
    localparam logic [7:0] FAST_MIN_RST = 8'hB4;
    localparam logic [1:0] RESET_RAIL = 2'h0;

    // Analog comparator bundle, all synchronised levels
    typedef struct packed {
        logic in_above_lockout;
        logic in_above_cell_sleep;
        logic in_below_ovp;
        logic therm_in_window;
        logic cell_above_short;
        logic cell_above_deep;
        logic cell_below_recharge;
        logic cell_above_cutoff;
        logic current_at_taper;
        logic cv_loop_active;
        logic sag_loop_active;
        logic thermal_reg_active;
        logic rail_below_droop;
        logic rail_below_enter;
        logic rail_within_exit;
        logic shipmode;
    } ccpp_sense_type;

    // Switch and loop drives
    typedef struct packed {
        logic cell_switch_on;
        logic input_switch_on;
        logic rail_pulldown_on;
        logic supplement_on;
        logic droop_reduce;
    } ccpp_drive_type;

endpackage

// *** src/ccpp_sync.sv ***
// Two-flop synchroniser for a vector of comparator levels
`timescale 1ns/1ps
`default_nettype none
module ccpp_sync #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // First stage read only by the second
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** src/ccpp_timer.sv ***
// Minute-tick safety timer with half-rate slowdown
`timescale 1ns/1ps
`default_nettype none
module ccpp_timer #(
    parameter longint TICK_CYCLES = ccpp_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic clear,
    input wire logic slow,
    input wire logic [9:0] limit_min,
    output logic expired
);
    logic [39:0] div_q;
    logic half_q;
    logic [9:0] min_q;
    wire tick = run && (div_q == 40'(TICK_CYCLES - 1));
    // Extended timing counts every other minute tick
    wire count = tick && (!slow || half_q);

    always_ff @(posedge clk) begin
        if (srst || clear) begin
            div_q <= '0;
            half_q <= 1'b0;
            min_q <= '0;
        end else if (run) begin
            div_q <= tick ? '0 : div_q + 40'h1;
            if (tick) half_q <= ~half_q;
            if (count && min_q != limit_min) min_q <= min_q + 10'h1;
        end
    end

    assign expired = (min_q >= limit_min);
endmodule
`default_nettype wire

// *** src/ccpp_ctrl.sv ***
// Charge sequencer and power path arbitration top level
// Functional notes
// - Start charging only with valid input, permission
// - Inhibit with thermistor in window: cell switch off
// - Supplement works regardless of charge inhibit
// - Below short threshold: trickle at trickle current
// - Trickle plus precharge share quarter timer
// - Precharge current, then fast past deep threshold
// - No termination: precharge is fast/5
// - Clamp regulation target at 4.65 V
// - Taper current reached: done, set complete flag
// - After done: cell switch off, rail from input
// - Terminate only in CV, no sag/droop/thermal
// - Recharge threshold restarts cycle, clears timers
// - Two select bits choose or disable sag floor
// - Sag loop active sets floor active flag
// - Sag active with double enable slows timer
// - Droop reduces current; then supplement
// - Droop 100 mV; off bit ignored when tracking
// - Supplement between entry and exit margins
// - Supplement: no termination, guard on, above cutoff (guard only follows its enable bit)
// - Decode four rail source select codes
// - Normal: input if valid, else cell
// - Input lost, cell above cutoff: rail to cell
// - Force cell below cutoff falls back to normal
`timescale 1ns/1ps
`default_nettype none
module ccpp_ctrl #(
    parameter longint TICK_CYCLES = ccpp_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire ccpp_pkg::ccpp_sense_type sense_async,
    input wire logic charge_inhibit,
    input wire logic term_enable,
    input wire logic double_timer_enable,
    input wire logic droop_loop_off,
    input wire logic rail_tracking_mode,
    input wire logic cell_overcurrent_enable,
    input wire logic input_floor_sel_lo,
    input wire logic input_floor_sel_hi,
    input wire logic [1:0] rail_source_select,
    input wire logic [9:0] cell_target_voltage,
    input wire logic [9:0] fast_fill_current,
    input wire logic [9:0] pre_fill_current,
    input wire logic [9:0] fast_timer_min,
    input wire logic charge_complete_clear,
    output ccpp_pkg::ccpp_drive_type drive,
    output ccpp_pkg::ccpp_cur_type cur_level,
    output logic [9:0] cur_setting,
    output logic [9:0] applied_target,
    output logic [1:0] sag_select,
    output logic sag_enable,
    output logic [7:0] droop_headroom,
    output logic cell_overcurrent_guard,
    output logic input_floor_active_flag,
    output logic charge_complete_flag,
    output logic safety_fault_flag,
    output ccpp_pkg::ccpp_state_type state
);
    ////////////////////////////////////////////////////////////////////
    // Input synchronisation
    ccpp_pkg::ccpp_sense_type s;

    ccpp_sync #(
        .WIDTH($bits(ccpp_pkg::ccpp_sense_type))
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .async_in(sense_async),
        .sync_out(s)
    );

    ////////////////////////////////////////////////////////////////////
    // Decodes
    ccpp_pkg::ccpp_state_type state_d;
    logic supp_q;
    wire in_valid = s.in_above_lockout && s.in_above_cell_sleep
        && s.in_below_ovp;
    // Inhibit only gates when thermistor pin sits in its window
    wire blocked = charge_inhibit && s.therm_in_window;
    wire may_start = in_valid && !blocked;
    // Force cell falls back to normal with a weak cell
    wire [1:0] mode_eff = (rail_source_select == ccpp_pkg::RAIL_FORCE_CELL
        && !s.cell_above_cutoff) ? ccpp_pkg::RAIL_NORMAL
        : rail_source_select;
    wire mode_force = (mode_eff == ccpp_pkg::RAIL_FORCE_CELL);
    wire mode_off = mode_eff[1];
    wire charging = (state == ccpp_pkg::ST_TRICKLE)
        || (state == ccpp_pkg::ST_PRE) || (state == ccpp_pkg::ST_FAST);
    // Termination only for a CV taper, never under other loops
    wire term_ok = term_enable && s.cv_loop_active && !s.sag_loop_active
        && !s.thermal_reg_active && !s.rail_below_droop
        && !supp_q;
    wire taper_done = (state == ccpp_pkg::ST_FAST) && s.current_at_taper
        && term_ok;
    wire restart = (state == ccpp_pkg::ST_DONE)
        && s.cell_below_recharge;
    wire sag_on = ({input_floor_sel_hi, input_floor_sel_lo}
        != ccpp_pkg::SAG_OFF_CODE);

    ////////////////////////////////////////////////////////////////////
    // Safety timer: precharge limit is a quarter of the fast limit
    wire in_pre = (state == ccpp_pkg::ST_TRICKLE)
        || (state == ccpp_pkg::ST_PRE);
    wire [9:0] limit = in_pre ? (fast_timer_min >> ccpp_pkg::PRE_SHIFT)
        : fast_timer_min;
    wire tmr_expired;
    // Clear on cycle start, restart and any entry to fast from trickle or precharge
    wire tmr_clear = (state == ccpp_pkg::ST_IDLE) || restart
        || (state_d == ccpp_pkg::ST_FAST
        && state != ccpp_pkg::ST_FAST);
    wire tmr_slow = s.sag_loop_active && double_timer_enable;

    ccpp_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .clk(clk),
        .srst(srst),
        .run(charging),
        .clear(tmr_clear),
        .slow(tmr_slow),
        .limit_min(limit),
        .expired(tmr_expired)
    );

    ////////////////////////////////////////////////////////////////////
    // Charge sequencer next state
    always_comb begin
        state_d = state;
        unique case (state)
            ccpp_pkg::ST_IDLE: begin
                if (may_start && !mode_force && !mode_off) begin
                    state_d = ccpp_pkg::ST_TRICKLE;
                end
            end
            ccpp_pkg::ST_TRICKLE, ccpp_pkg::ST_PRE, ccpp_pkg::ST_FAST: begin
                if (!may_start || mode_force || mode_off) begin
                    state_d = ccpp_pkg::ST_IDLE;
                end else if (tmr_expired) begin
                    state_d = ccpp_pkg::ST_FAULT;
                end else if (taper_done) begin
                    state_d = ccpp_pkg::ST_DONE;
                end else if (s.cell_above_deep) begin
                    state_d = ccpp_pkg::ST_FAST;
                end else if (s.cell_above_short) begin
                    state_d = ccpp_pkg::ST_PRE;
                end else begin
                    state_d = ccpp_pkg::ST_TRICKLE;
                end
            end
            ccpp_pkg::ST_DONE: begin
                if (!in_valid) begin
                    state_d = ccpp_pkg::ST_IDLE;
                end else if (restart && may_start) begin
                    state_d = ccpp_pkg::ST_TRICKLE;
                end
            end
            ccpp_pkg::ST_FAULT: begin
                // Held until input is cycled
                if (!in_valid) state_d = ccpp_pkg::ST_IDLE;
            end
            default: state_d = ccpp_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) state <= ccpp_pkg::ST_IDLE;
        else state <= state_d;
    end

    ////////////////////////////////////////////////////////////////////
    // Supplement: hysteresis between entry and exit margins
    wire supp_d = s.cell_above_cutoff && !mode_off
        && (supp_q ? !s.rail_within_exit
        : (s.rail_below_enter && in_valid));

    always_ff @(posedge clk) begin
        if (srst) supp_q <= 1'b0;
        else supp_q <= supp_d;
    end

    ////////////////////////////////////////////////////////////////////
    // Current level and setting
    wire [9:0] pre_cur = term_enable ? pre_fill_current
        : 10'(fast_fill_current / ccpp_pkg::PRE_DIV);
    ccpp_pkg::ccpp_cur_type cur_d;
    // Droop reduces to zero before supplement takes over
    wire droop_cut = s.rail_below_droop || supp_d;
    assign cur_d = (state_d == ccpp_pkg::ST_TRICKLE) ? ccpp_pkg::CUR_TRICKLE
        : (state_d == ccpp_pkg::ST_PRE) ? ccpp_pkg::CUR_PRE
        : (state_d == ccpp_pkg::ST_FAST) ? ccpp_pkg::CUR_FAST
        : ccpp_pkg::CUR_OFF;
    wire [9:0] set_d = (cur_d == ccpp_pkg::CUR_PRE) ? pre_cur
        : (cur_d == ccpp_pkg::CUR_FAST) ? fast_fill_current
        : 10'h000;
    wire [9:0] target_d = (cell_target_voltage > ccpp_pkg::TARGET_MAX_CODE)
        ? ccpp_pkg::TARGET_MAX_CODE : cell_target_voltage;
    // Tracking mode already carries its own headroom
    wire [7:0] head_d = rail_tracking_mode ? ccpp_pkg::TRACK_MV
        : droop_loop_off ? ccpp_pkg::DROOP_LOW_MV
        : ccpp_pkg::DROOP_MV;

    ////////////////////////////////////////////////////////////////////
    // Power path drives
    wire chg_sw = (cur_d != ccpp_pkg::CUR_OFF) && !droop_cut;
    ccpp_pkg::ccpp_drive_type drive_d;
    assign drive_d.input_switch_on = !mode_off && !mode_force
        && !s.shipmode && in_valid;
    // Cell feeds rail when input absent, forced, or assisting
    assign drive_d.cell_switch_on = !mode_off && !s.shipmode
        && (chg_sw || supp_d || (s.cell_above_cutoff
        && (mode_force || !in_valid)));
    assign drive_d.rail_pulldown_on = (mode_eff == ccpp_pkg::RAIL_PULLDOWN)
        || s.shipmode;
    assign drive_d.supplement_on = supp_d;
    assign drive_d.droop_reduce = s.rail_below_droop && charging;

    always_ff @(posedge clk) begin
        if (srst) begin
            drive <= '0;
            cur_level <= ccpp_pkg::CUR_OFF;
            cur_setting <= '0;
            applied_target <= '0;
            sag_select <= '0;
            sag_enable <= 1'b0;
            droop_headroom <= ccpp_pkg::DROOP_MV;
            cell_overcurrent_guard <= 1'b0;
            input_floor_active_flag <= 1'b0;
        end else begin
            drive <= drive_d;
            cur_level <= droop_cut ? ccpp_pkg::CUR_OFF : cur_d;
            cur_setting <= droop_cut ? 10'h000 : set_d;
            applied_target <= target_d;
            sag_select <= {input_floor_sel_hi, input_floor_sel_lo};
            sag_enable <= sag_on;
            droop_headroom <= head_d;
            cell_overcurrent_guard <= cell_overcurrent_enable;
            input_floor_active_flag <= s.sag_loop_active && sag_on;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sticky flags; a set in the same cycle beats the clear
    always_ff @(posedge clk) begin
        if (srst) begin
            charge_complete_flag <= 1'b0;
            safety_fault_flag <= 1'b0;
        end else begin
            if (taper_done) charge_complete_flag <= 1'b1;
            else if (charge_complete_clear || restart)
                charge_complete_flag <= 1'b0;
            if (state_d == ccpp_pkg::ST_FAULT) safety_fault_flag <= 1'b1;
            else if (state_d == ccpp_pkg::ST_IDLE) safety_fault_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_inhibit;
        @(posedge clk) disable iff (srst)
        (charge_inhibit && s.therm_in_window) |=> !charging;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("charging under inhibit");

    // Cell below short threshold while charging goes on
    property p_trickle;
        @(posedge clk) disable iff (srst)
        (charging && may_start && !mode_force && !mode_off && !tmr_expired
        && !taper_done && !s.cell_above_short && !s.cell_above_deep
        && !droop_cut) |=> cur_level == ccpp_pkg::CUR_TRICKLE;
    endproperty
    a_trickle: assert property (p_trickle) else $error("bad trickle level");

    property p_clamp;
        @(posedge clk) disable iff (srst)
        1'b1 |=> applied_target <= ccpp_pkg::TARGET_MAX_CODE;
    endproperty
    a_clamp: assert property (p_clamp) else $error("target above clamp");

    property p_done;
        @(posedge clk) disable iff (srst)
        (taper_done && may_start && !tmr_expired && !mode_force && !mode_off)
        |=> charge_complete_flag && state == ccpp_pkg::ST_DONE;
    endproperty
    a_done: assert property (p_done) else $error("done not flagged");

    property p_term_block;
        @(posedge clk) disable iff (srst)
        (s.sag_loop_active || supp_q) |-> !taper_done;
    endproperty
    a_term_block: assert property (p_term_block) else $error("blocked term");

    property p_floor;
        @(posedge clk) disable iff (srst)
        (s.sag_loop_active && sag_on) |=> input_floor_active_flag;
    endproperty
    a_floor: assert property (p_floor) else $error("floor flag missing");

    property p_pulldown;
        @(posedge clk) disable iff (srst)
        (rail_source_select == ccpp_pkg::RAIL_PULLDOWN)
        |=> drive.rail_pulldown_on && !drive.input_switch_on;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("no pulldown");

    sequence s_lost_input;
        charging ##1 !in_valid;
    endsequence
    property p_idle;
        @(posedge clk) disable iff (srst)
        s_lost_input |=> state == ccpp_pkg::ST_IDLE;
    endproperty
    a_idle: assert property (p_idle) else $error("no idle on loss");
endmodule
`default_nettype wire

// *** verif/ccpp_host_model.sv ***
// Behavioural host holding the charger configuration levels
`timescale 1ns/1ps
`default_nettype none
module ccpp_host_model (
    output var logic charge_inhibit,
    output var logic term_enable,
    output var logic double_timer_enable,
    output var logic droop_loop_off,
    output var logic rail_tracking_mode,
    output var logic cell_overcurrent_enable,
    output var logic input_floor_sel_lo,
    output var logic input_floor_sel_hi,
    output var logic [1:0] rail_source_select,
    output var logic [9:0] cell_target_voltage,
    output var logic [9:0] fast_fill_current,
    output var logic [9:0] pre_fill_current,
    output var logic [9:0] fast_timer_min,
    output var logic charge_complete_clear
);
    ////////////////////////////////////////////////////////////////////////
    // Power-up levels; a real host writes these before enabling charge
    initial begin
        charge_inhibit = 1'b0;
        term_enable = 1'b1;
        double_timer_enable = 1'b0;
        droop_loop_off = 1'b0;
        rail_tracking_mode = 1'b0;
        cell_overcurrent_enable = 1'b1;
        input_floor_sel_lo = 1'b0;
        input_floor_sel_hi = 1'b0;
        rail_source_select = 2'h0;
        cell_target_voltage = 10'h1A4;
        fast_fill_current = 10'h0C8;
        pre_fill_current = 10'h03C;
        fast_timer_min = 10'h028;
        charge_complete_clear = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Both select bits change together so no mixed code is seen
    task automatic set_sag(input logic [1:0] code);
        {input_floor_sel_hi, input_floor_sel_lo} = code;
    endtask
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the charge sequencer and power path
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [9:0] tgt;
        logic [1:0] sag;
        logic off;
        logic trk;
        logic [1:0] rail;
        logic cut;
        logic [9:0] e_tgt;
        logic e_en;
        logic [7:0] e_hd;
        logic e_in;
        logic e_pd;
    } ccpp_row_type;

    logic clk = 1'b0;
    logic srst = 1'b1;
    ccpp_pkg::ccpp_sense_type sense = '0;
    int miscompares = 0;
    int compares = 0;
    ccpp_row_type rows [5];
    wire logic inh, term, dbl, off, trk, ocp, s_lo, s_hi, clr;
    wire logic [1:0] rail;
    wire logic [9:0] tgt, fast, pre, tmin;
    ccpp_pkg::ccpp_drive_type drive;
    ccpp_pkg::ccpp_cur_type cur_level;
    ccpp_pkg::ccpp_state_type state;
    logic [9:0] cur_setting, applied_target;
    logic [1:0] sag_select;
    logic [7:0] droop_headroom;
    logic sag_enable, guard, floor_flag, done_flag, fault_flag;

    // Clock at 250 MHz
    always #2 clk = ~clk;

    ccpp_host_model host (
        .charge_inhibit(inh), .term_enable(term),
        .double_timer_enable(dbl), .droop_loop_off(off),
        .rail_tracking_mode(trk), .cell_overcurrent_enable(ocp),
        .input_floor_sel_lo(s_lo), .input_floor_sel_hi(s_hi),
        .rail_source_select(rail), .cell_target_voltage(tgt),
        .fast_fill_current(fast), .pre_fill_current(pre),
        .fast_timer_min(tmin), .charge_complete_clear(clr)
    );

    // Short minute tick keeps the safety timer runs brief
    ccpp_ctrl #(.TICK_CYCLES(10)) dut (
        .clk(clk), .srst(srst), .sense_async(sense),
        .charge_inhibit(inh), .term_enable(term),
        .double_timer_enable(dbl), .droop_loop_off(off),
        .rail_tracking_mode(trk), .cell_overcurrent_enable(ocp),
        .input_floor_sel_lo(s_lo), .input_floor_sel_hi(s_hi),
        .rail_source_select(rail), .cell_target_voltage(tgt),
        .fast_fill_current(fast), .pre_fill_current(pre),
        .fast_timer_min(tmin), .charge_complete_clear(clr),
        .drive(drive), .cur_level(cur_level), .cur_setting(cur_setting),
        .applied_target(applied_target), .sag_select(sag_select),
        .sag_enable(sag_enable), .droop_headroom(droop_headroom),
        .cell_overcurrent_guard(guard),
        .input_floor_active_flag(floor_flag),
        .charge_complete_flag(done_flag),
        .safety_fault_flag(fault_flag), .state(state)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (miscompares == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [9:0] e,
                       input logic [9:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_b(input string nm, input logic e, input logic g);
        chk(nm, {9'h000, e}, {9'h000, g});
    endtask

    task automatic chk_st(input ccpp_pkg::ccpp_state_type e);
        chk("state", {7'h00, e}, {7'h00, state});
    endtask

    // Sync plus register: three edges from pin to output
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    // Input levels set valid or lost per v, thermistor in window
    task automatic power(input logic v);
        sense.in_above_lockout = v;
        sense.in_above_cell_sleep = v;
        sense.in_below_ovp = v;
        sense.therm_in_window = 1'b1;
        settle();
    endtask

    // Hold in trickle and watch the shared precharge limit expire
    task automatic t_fault(input logic d, input int lo, input int hi);
        power(1'b0);
        sense = '0;
        host.double_timer_enable = d;
        sense.sag_loop_active = d;
        power(1'b1);
        chk_st(ccpp_pkg::ST_TRICKLE);
        chk_b("floor_flag", d, floor_flag);
        repeat (lo) @(negedge clk);
        chk_b("early_fault", 1'b0, fault_flag);
        repeat (hi - lo) @(negedge clk);
        chk_b("late_fault", 1'b1, fault_flag);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rows[0] = '{10'h1D0, 2'h0, 1'b0, 1'b0, 2'h0, 1'b1,
                    10'h1D0, 1'b1, 8'h64, 1'b1, 1'b0};
        rows[1] = '{10'h1D1, 2'h1, 1'b1, 1'b0, 2'h1, 1'b1,
                    10'h1D1, 1'b1, 8'h32, 1'b0, 1'b0};
        rows[2] = '{10'h1D2, 2'h2, 1'b0, 1'b1, 2'h1, 1'b0,
                    10'h1D1, 1'b1, 8'hE1, 1'b1, 1'b0};
        rows[3] = '{10'h3FF, 2'h3, 1'b1, 1'b1, 2'h2, 1'b1,
                    10'h1D1, 1'b0, 8'hE1, 1'b0, 1'b0};
        rows[4] = '{10'h064, 2'h3, 1'b0, 1'b0, 2'h3, 1'b1,
                    10'h064, 1'b0, 8'h64, 1'b0, 1'b1};
        repeat (4) @(negedge clk);
        chk_st(ccpp_pkg::ST_IDLE);
        chk("headroom", 10'h064, {2'h0, droop_headroom});
        chk_b("cell_sw", 1'b0, drive.cell_switch_on);
        srst = 1'b0;
        power(1'b1);
        // Table: clamp, sag select, headroom and rail source decode
        foreach (rows[i]) begin
            host.cell_target_voltage = rows[i].tgt;
            host.set_sag(rows[i].sag);
            host.droop_loop_off = rows[i].off;
            host.rail_tracking_mode = rows[i].trk;
            host.rail_source_select = rows[i].rail;
            sense.cell_above_cutoff = rows[i].cut;
            settle();
            chk("target", rows[i].e_tgt, applied_target);
            chk("sag_sel", {8'h00, rows[i].sag}, {8'h00, sag_select});
            chk_b("sag_en", rows[i].e_en, sag_enable);
            chk("headroom", {2'h0, rows[i].e_hd}, {2'h0, droop_headroom});
            chk_b("in_sw", rows[i].e_in, drive.input_switch_on);
            chk_b("pulldown", rows[i].e_pd, drive.rail_pulldown_on);
        end
        host.rail_source_select = 2'h0;
        host.set_sag(2'h0);
        host.droop_loop_off = 1'b0;
        host.rail_tracking_mode = 1'b0;
        host.cell_target_voltage = 10'h1A4;
        // Safety timer: quarter limit, then doubled under sag
        host.fast_timer_min = 10'h008;
        t_fault(1'b0, 12, 40);
        t_fault(1'b1, 32, 80);
        host.double_timer_enable = 1'b0;
        host.fast_timer_min = 10'h028;
        // Full charge walk
        power(1'b0);
        sense = '0;
        power(1'b1);
        chk_st(ccpp_pkg::ST_TRICKLE);
        chk("cur", 10'h001, {8'h00, cur_level});
        chk_b("cell_sw", 1'b1, drive.cell_switch_on);
        sense.cell_above_short = 1'b1;
        settle();
        chk_st(ccpp_pkg::ST_PRE);
        chk("pre_cur", 10'h03C, cur_setting);
        host.term_enable = 1'b0;
        settle();
        chk("pre_cur", 10'h028, cur_setting);
        host.term_enable = 1'b1;
        sense.cell_above_deep = 1'b1;
        sense.cell_above_cutoff = 1'b1;
        settle();
        chk_st(ccpp_pkg::ST_FAST);
        chk("fast_cur", 10'h0C8, cur_setting);
        sense.current_at_taper = 1'b1;
        settle();
        chk_st(ccpp_pkg::ST_FAST);
        sense.cv_loop_active = 1'b1;
        sense.sag_loop_active = 1'b1;
        settle();
        chk_st(ccpp_pkg::ST_FAST);
        sense.sag_loop_active = 1'b0;
        sense.rail_below_droop = 1'b1;
        sense.rail_below_enter = 1'b1;
        settle();
        chk_st(ccpp_pkg::ST_FAST);
        chk_b("reduce", 1'b1, drive.droop_reduce);
        chk_b("supp", 1'b1, drive.supplement_on);
        chk_b("guard", 1'b1, guard);
        sense.rail_below_droop = 1'b0;
        sense.rail_below_enter = 1'b0;
        sense.rail_within_exit = 1'b1;
        settle();
        chk_b("supp", 1'b0, drive.supplement_on);
        // Termination waits one more cycle for the assist flag to drop
        @(negedge clk);
        chk_st(ccpp_pkg::ST_DONE);
        chk_b("done", 1'b1, done_flag);
        chk_b("cell_sw", 1'b0, drive.cell_switch_on);
        chk_b("in_sw", 1'b1, drive.input_switch_on);
        sense.cell_below_recharge = 1'b1;
        settle();
        chk_b("restart", 1'b1, state !== ccpp_pkg::ST_DONE);
        host.charge_inhibit = 1'b1;
        power(1'b0);
        power(1'b1);
        chk_b("cell_sw", 1'b0, drive.cell_switch_on);
        sense.rail_within_exit = 1'b0;
        sense.rail_below_enter = 1'b1;
        settle();
        chk_b("supp", 1'b1, drive.supplement_on);
        host.cell_overcurrent_enable = 1'b0;
        @(negedge clk);
        chk_b("guard", 1'b0, guard);
        host.charge_inhibit = 1'b0;
        sense.rail_below_enter = 1'b0;
        sense.cell_below_recharge = 1'b0;
        power(1'b1);
        sense.in_above_lockout = 1'b0;
        settle();
        chk_st(ccpp_pkg::ST_IDLE);
        chk_b("in_sw", 1'b0, drive.input_switch_on);
        chk_b("cell_sw", 1'b1, drive.cell_switch_on);
        // Ship mode drops the rail and pulls it down
        sense.shipmode = 1'b1;
        settle();
        chk_b("pulldown", 1'b1, drive.rail_pulldown_on);
        chk_b("cell_sw", 1'b0, drive.cell_switch_on);
        give_verdict();
    end
endmodule
`default_nettype wire
